// ===== rtl/cmtrf_pkg.sv
// Constants and types shared by the CAN mode, timing and receiver flag block.
// Assumes a 32-bit APB register bus, one word per register.
`default_nettype none

package cmtrf_pkg;

    // ********************************************************************
    // Register indices, byte address is four times the index
    // ********************************************************************
    localparam int unsigned IDX_MODE0 = 0;
    localparam int unsigned IDX_MODE1 = 1;
    localparam int unsigned IDX_BT0   = 2;
    localparam int unsigned IDX_BT1   = 3;
    localparam int unsigned IDX_RFLG  = 4;
    localparam int unsigned IDX_RIER  = 5;

    // ********************************************************************
    // Reset values and field positions
    // ********************************************************************
    localparam logic       SOFT_RESET_RESET = 1'h1;
    localparam logic [7:0] MODE1_RESET      = 8'h00;
    localparam logic [7:0] BT0_RESET        = 8'h00;
    localparam logic [7:0] BT1_RESET        = 8'h00;
    localparam logic [7:0] RFLG_RESET       = 8'h00;
    localparam logic [7:0] RIER_RESET       = 8'h00;
    localparam int unsigned M0_SYNCED     = 4;
    localparam int unsigned M0_SLEEP_ACK  = 2;
    localparam int unsigned M0_SLEEP_REQ  = 1;
    localparam int unsigned M0_SOFT_RESET = 0;
    localparam int unsigned M1_LOOPBACK   = 2;
    localparam int unsigned M1_WAKE_FILT  = 1;
    localparam int unsigned M1_CLOCK_SEL  = 0;
    localparam int unsigned RF_WAKE       = 7;
    localparam int unsigned RF_RX_WARN    = 6;
    localparam int unsigned RF_TX_WARN    = 5;
    localparam int unsigned RF_RX_PASSIVE = 4;
    localparam int unsigned RF_TX_PASSIVE = 3;
    localparam int unsigned RF_BUS_OFF    = 2;
    localparam logic [7:0]  RF_ERR_MASK   = 8'h7c;

    // ********************************************************************
    // Protocol counts and timing
    // ********************************************************************
    localparam logic [3:0] RECESSIVE_RUN = 4'hb;
    localparam logic [7:0] BUS_OFF_SEQS  = 8'h80;
    localparam logic [8:0] WARN_LO       = 9'h060;
    localparam logic [8:0] WARN_HI       = 9'h07f;
    localparam logic [8:0] PASSIVE_ABOVE = 9'h07f;
    localparam logic [8:0] BUS_OFF_ABOVE = 9'h0ff;
    localparam int unsigned CLK_PERIOD_NS  = 5;
    localparam int unsigned WAKE_PULSE_NS  = 2000;
    localparam int unsigned WAKE_PULSE_RAW = (WAKE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [15:0] WAKE_PULSE_CYC = 16'(WAKE_PULSE_RAW < 1 ? 1 : WAKE_PULSE_RAW);

    // ********************************************************************
    // Types
    // ********************************************************************
    typedef struct packed {
        logic [1:0] jump_width;
        logic [5:0] tq_prescaler;
    } cmtrf_bt0_type;

    typedef struct packed {
        logic       triple_sample;
        logic [2:0] time_segment_two;
        logic [3:0] time_segment_one;
    } cmtrf_bt1_type;

    typedef enum logic [1:0] {
        SY_RESET = 2'b00,
        SY_WAIT  = 2'b01,
        SY_OFF   = 2'b10,
        SY_DONE  = 2'b11
    } cmtrf_sync_type;

    typedef enum logic [0:0] {
        SL_RUN   = 1'b0,
        SL_SLEEP = 1'b1
    } cmtrf_sleep_type;

endpackage

`default_nettype wire

// ===== rtl/cmtrf_core.sv
// Mode control, bit timing and receiver flags of a CAN protocol controller.
// Assumes an APB master, a protocol engine that supplies the transmit bit
// and error counts, and clock tick inputs synchronous to pclk.
//
// Function
// - Sleep acknowledge bit shows internal sleep
// - Sleep only when bus idle, until activity
// - Clearing sleep request wakes without wake flag
// - Soft reset aborts frames, drops bus sync
// - Soft reset restores mode, flags, enables
// - Soft reset leaves error counters alone
// - Configuration writes only during soft reset
// - Synchronise after eleven recessive bits
// - Bus-off waits 128 runs of eleven
// - Loop-back feeds transmitter to receiver internally
// - Loop-back skips acknowledge, takes own frames
// - Wake filter demands long dominant pulse
// - Clock select picks bus or crystal/2
// - Jump width is code plus one quanta
// - Prescaler divides by code plus one
// - Triple sample takes majority of three
// - Segment one/two lengths are code plus one
// - Sync segment, transmit point, sample point
// - Flags clear by write one after cause
// - Wake clears acknowledge, then sets flag
// - Warning flags for counts 96 to 127
// - Passive flags for counts above 127
// - Synchronised status bit is readable
// - Bus-off above 255 raises bus-off flag
//
// The register addresses and the APB interface to the registers were decided locally.
`default_nettype none

module cmtrf_core
    import cmtrf_pkg::*;
#(
    parameter int unsigned ADDR_W = 8
)
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic [31:0]            prdata,
    input  wire logic              pll_bus_clock,
    input  wire logic              crystal_clock,
    input  wire logic              bus_receive_pin,
    output logic                   bus_transmit_pin,
    input  wire logic              tx_bit,
    input  wire logic              tx_active,
    input  wire logic [7:0]        rx_err_count,
    input  wire logic [8:0]        tx_err_count,
    output logic                   rx_bit,
    output logic                   sample_strobe,
    output logic                   tx_point_strobe,
    output logic                   protocol_abort,
    output logic                   config_write_ok,
    output logic                   loopback_active,
    output logic                   module_clock_select,
    output logic                   wake_irq,
    output logic                   error_irq
);

    if (ADDR_W < 5) begin : g_addr_check
        $error("ADDR_W too small for the register map");
    end

    localparam int unsigned IW = ADDR_W - 2;

    // ********************************************************************
    // Helpers
    // ********************************************************************
    // True when a word index selects the given register.
    function automatic logic reg_sel(input logic [IW-1:0] idx, input int unsigned n);
        reg_sel = (idx == IW'(n));
    endfunction

    // True when a count lies in an inclusive range.
    function automatic logic in_range(input logic [8:0] v, input logic [8:0] lo,
                                      input logic [8:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction

    // ********************************************************************
    // State
    // ********************************************************************
    logic            soft_reset_q;
    logic            sleep_req_q;
    logic [7:0]      mode1_q;
    cmtrf_bt0_type   bt0_q;
    cmtrf_bt1_type   bt1_q;
    logic [7:0]      flags_q;
    logic [7:0]      flags_d;
    logic [7:0]      ier_q;
    logic [7:0]      cond_q;
    logic [7:0]      cond_now;
    cmtrf_sync_type  sync_q;
    cmtrf_sleep_type sleep_q;
    logic            wake_pend_q;
    logic            xtal_half_q;
    logic [5:0]      presc_q;
    logic [4:0]      pos_q;
    logic [2:0]      hist_q;
    logic            rx_prev_q;
    logic [3:0]      run_q;
    logic [7:0]      seq_q;
    logic [15:0]     dom_q;
    logic            tx_q;
    logic            rx_bit_q;
    logic [31:0]     prdata_q;

    logic [IW-1:0] idx;
    logic          wr;
    logic          rd_setup;
    logic          mtick;
    logic          tq_end;
    logic [4:0]    last_pos;
    logic [4:0]    triple_sample_pos;
    logic [4:0]    jump;
    logic          rx_in;
    logic          fall;
    logic          sample_now;
    logic          bit_val;
    logic          run_done;
    logic          bus_idle;
    logic          bus_off;
    logic          wake_evt;
    logic [7:0]    rd_mux;

    // ********************************************************************
    // APB slave
    // ********************************************************************
    // Zero wait states; unmapped word indices answer with an error.
    assign idx      = paddr[ADDR_W-1:2];
    assign wr       = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && (idx > IW'(IDX_RIER));
    assign prdata   = prdata_q;

    // Read multiplexer, reserved bits read as zero except interrupt enable bits 1:0, which read back as written.
    always_comb
    begin
        rd_mux = 8'h00;
        if (reg_sel(idx, IDX_MODE0))
        begin
            rd_mux[M0_SYNCED]     = (sync_q == SY_DONE);
            rd_mux[M0_SLEEP_ACK]  = (sleep_q == SL_SLEEP);
            rd_mux[M0_SLEEP_REQ]  = sleep_req_q;
            rd_mux[M0_SOFT_RESET] = soft_reset_q;
        end
        else if (reg_sel(idx, IDX_MODE1))
            rd_mux = mode1_q;
        else if (reg_sel(idx, IDX_BT0))
            rd_mux = bt0_q;
        else if (reg_sel(idx, IDX_BT1))
            rd_mux = bt1_q;
        else if (reg_sel(idx, IDX_RFLG))
            rd_mux = flags_q;
        else if (reg_sel(idx, IDX_RIER))
            rd_mux = ier_q;
    end

    // Read data is captured in the setup cycle for the access cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_q <= 32'h00000000;
        else if (rd_setup)
            prdata_q <= {24'h000000, rd_mux};
    end

    // ********************************************************************
    // Mode control registers
    // ********************************************************************
    // Soft reset and sleep request; soft reset also drops the request.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            soft_reset_q <= SOFT_RESET_RESET;
            sleep_req_q  <= 1'b0;
        end
        else if (wr && reg_sel(idx, IDX_MODE0))
        begin
            soft_reset_q <= pwdata[M0_SOFT_RESET];
            sleep_req_q  <= pwdata[M0_SLEEP_REQ] && !pwdata[M0_SOFT_RESET];
        end
        else if (soft_reset_q)
            sleep_req_q <= 1'b0;
    end

    // Configuration registers accept writes only while in soft reset.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode1_q <= MODE1_RESET;
            bt0_q   <= BT0_RESET;
            bt1_q   <= BT1_RESET;
        end
        else if (wr && soft_reset_q)
        begin
            if (reg_sel(idx, IDX_MODE1))
                mode1_q <= {5'h00, pwdata[2:0]};
            if (reg_sel(idx, IDX_BT0))
                bt0_q <= pwdata[7:0];
            if (reg_sel(idx, IDX_BT1))
                bt1_q <= pwdata[7:0];
        end
    end

    // Interrupt enables, held cleared during soft reset.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ier_q <= RIER_RESET;
        else if (soft_reset_q)
            ier_q <= RIER_RESET;
        else if (wr && reg_sel(idx, IDX_RIER))
            ier_q <= pwdata[7:0];
    end

    assign protocol_abort      = soft_reset_q;
    assign config_write_ok     = soft_reset_q;
    assign loopback_active     = mode1_q[M1_LOOPBACK];
    assign module_clock_select = mode1_q[M1_CLOCK_SEL];

    // ********************************************************************
    // Module clock and time quantum
    // ********************************************************************
    // Crystal ticks are halved; bus clock ticks pass straight through.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            xtal_half_q <= 1'b0;
        else if (crystal_clock)
            xtal_half_q <= !xtal_half_q;
    end

    assign mtick = mode1_q[M1_CLOCK_SEL] ? pll_bus_clock
                                         : (crystal_clock && xtal_half_q);
    assign tq_end   = mtick && (presc_q == bt0_q.tq_prescaler);
    assign triple_sample_pos = 5'(bt1_q.time_segment_one) + 5'h01;
    assign last_pos = triple_sample_pos + 5'(bt1_q.time_segment_two) + 5'h01;
    assign jump     = 5'(bt0_q.jump_width) + 5'h01;

    // Loop-back feeds the transmit stream back and ignores the pin.
    assign rx_in = mode1_q[M1_LOOPBACK] ? tx_bit : bus_receive_pin;
    assign fall  = rx_prev_q && !rx_in;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rx_prev_q <= 1'b1;
        else
            rx_prev_q <= rx_in;
    end

    // ********************************************************************
    // Bit timing with hard and soft synchronisation
    // ********************************************************************
    // Position 0 is the sync segment; an edge elsewhere restarts the bit while the bus is idle or
    // unsynchronised, and otherwise moves the bit boundary by at most the jump width.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            presc_q <= 6'h00;
            pos_q   <= 5'h00;
        end
        else if (soft_reset_q)
        begin
            presc_q <= 6'h00;
            pos_q   <= 5'h00;
        end
        else if (fall && pos_q != 5'h00)
        begin
            presc_q <= 6'h00;
            if (bus_idle || sync_q != SY_DONE)
                pos_q <= 5'h00;
            else if (pos_q <= triple_sample_pos)
                pos_q <= (pos_q > jump) ? pos_q - jump : 5'h00;
            else if ((last_pos + 5'h01 - pos_q) <= jump)
                pos_q <= 5'h00;
            else
                pos_q <= pos_q + jump;
        end
        else if (mtick)
        begin
            presc_q <= tq_end ? 6'h00 : presc_q + 6'h01;
            if (tq_end)
                pos_q <= (pos_q == last_pos) ? 5'h00 : pos_q + 5'h01;
        end
    end

    // Sample history; the sample point is the newest of three.
    assign sample_now = tq_end && (pos_q == triple_sample_pos) && !soft_reset_q;
    assign bit_val    = bt1_q.triple_sample ?
                        ((hist_q[1] & hist_q[0]) | (hist_q[1] & rx_in) | (hist_q[0] & rx_in))
                        : rx_in;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hist_q   <= 3'h7;
            rx_bit_q <= 1'b1;
        end
        else if (tq_end)
        begin
            hist_q <= {hist_q[1:0], rx_in};
            if (sample_now)
                rx_bit_q <= bit_val;
        end
    end

    // Transmit value changes at the start of each sync segment.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tx_q <= 1'b1;
        else if (soft_reset_q)
            tx_q <= 1'b1;
        else if (tq_end && pos_q == last_pos)
            tx_q <= tx_bit;
    end

    assign rx_bit           = rx_bit_q;
    assign sample_strobe    = sample_now;
    assign tx_point_strobe  = tq_end && (pos_q == last_pos) && !soft_reset_q;
    assign bus_transmit_pin = mode1_q[M1_LOOPBACK] ? 1'b1 : tx_q;

    // ********************************************************************
    // Recessive run counting and synchronisation
    // ********************************************************************
    assign run_done = sample_now && bit_val && (run_q == RECESSIVE_RUN - 4'h1);
    assign bus_idle = (run_q == RECESSIVE_RUN);
    assign bus_off  = (tx_err_count > BUS_OFF_ABOVE);

    // Run length of recessive samples; restarts per sequence in bus-off.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            run_q <= 4'h0;
        else if (soft_reset_q || wake_evt)
            run_q <= 4'h0;
        else if (sample_now)
        begin
            if (!bit_val)
                run_q <= 4'h0;
            else if (run_done && sync_q == SY_OFF)
                run_q <= 4'h0;
            else if (!bus_idle)
                run_q <= run_q + 4'h1;
        end
    end

    // Synchronisation state after soft reset is released.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync_q <= SY_RESET;
            seq_q  <= 8'h00;
        end
        else if (soft_reset_q)
        begin
            sync_q <= SY_RESET;
            seq_q  <= 8'h00;
        end
        else
        begin
            case (sync_q)
                SY_RESET: sync_q <= bus_off ? SY_OFF : SY_WAIT;
                SY_WAIT:
                    if (run_done)
                        sync_q <= SY_DONE;
                SY_OFF:
                    if (run_done)
                    begin
                        seq_q <= seq_q + 8'h01;
                        if (seq_q == BUS_OFF_SEQS - 8'h01)
                            sync_q <= SY_DONE;
                    end
                SY_DONE: sync_q <= SY_DONE;
                default: sync_q <= SY_RESET;
            endcase
        end
    end

    // ********************************************************************
    // Sleep and wake-up
    // ********************************************************************
    // Consecutive dominant cycles for the wake filter.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            dom_q <= 16'h0000;
        else if (rx_in || sleep_q != SL_SLEEP)
            dom_q <= 16'h0000;
        else if (dom_q != WAKE_PULSE_CYC)
            dom_q <= dom_q + 16'h0001;
    end

    assign wake_evt = (sleep_q == SL_SLEEP) && sleep_req_q &&
                      (mode1_q[M1_WAKE_FILT] ? (dom_q == WAKE_PULSE_CYC - 16'h0001 && !rx_in)
                                             : fall);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sleep_q     <= SL_RUN;
            wake_pend_q <= 1'b0;
        end
        else
        begin
            wake_pend_q <= wake_evt;
            case (sleep_q)
                SL_RUN:
                    if (sleep_req_q && bus_idle && !tx_active)
                        sleep_q <= SL_SLEEP;
                SL_SLEEP:
                    if (!sleep_req_q || wake_evt)
                        sleep_q <= SL_RUN;
                default: sleep_q <= SL_RUN;
            endcase
        end
    end

    // ********************************************************************
    // Receiver flags
    // ********************************************************************
    // Cause levels; the wake cause is a single event and never lingers.
    always_comb
    begin
        cond_now                = 8'h00;
        cond_now[RF_RX_WARN]    = in_range({1'b0, rx_err_count}, WARN_LO, WARN_HI);
        cond_now[RF_TX_WARN]    = in_range(tx_err_count, WARN_LO, WARN_HI);
        cond_now[RF_RX_PASSIVE] = ({1'b0, rx_err_count} > PASSIVE_ABOVE);
        cond_now[RF_TX_PASSIVE] = (tx_err_count > PASSIVE_ABOVE);
        cond_now[RF_BUS_OFF]    = bus_off;
    end

    // Set on entering a cause; write-one clears once the cause ended.
    always_comb
    begin
        flags_d = flags_q;
        if (wr && reg_sel(idx, IDX_RFLG))
            flags_d = flags_q & ~(pwdata[7:0] & ~cond_now);
        flags_d          = flags_d | (cond_now & ~cond_q);
        flags_d[RF_WAKE] = flags_d[RF_WAKE] | wake_pend_q;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flags_q <= RFLG_RESET;
            cond_q  <= 8'h00;
        end
        else if (soft_reset_q)
        begin
            flags_q <= RFLG_RESET;
            cond_q  <= 8'h00;
        end
        else
        begin
            flags_q <= flags_d;
            cond_q  <= cond_now;
        end
    end

    // Interrupt requests from enabled flags.
    assign wake_irq  = flags_q[RF_WAKE] && ier_q[RF_WAKE];
    assign error_irq = |(flags_q & ier_q & RF_ERR_MASK);

endmodule

`default_nettype wire

// ===== bench/cmtrf_assertions.sv
// Concurrent checks on the block's ports.
// Assumes a bind into cmtrf_core.
`default_nettype none
module cmtrf_assertions
#(
    parameter int unsigned ADDR_W = 8
)
(
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              bus_transmit_pin,
    input wire logic              rx_bit,
    input wire logic              sample_strobe,
    input wire logic              protocol_abort,
    input wire logic              config_write_ok,
    input wire logic              loopback_active,
    input wire logic              module_clock_select,
    input wire logic              wake_irq,
    input wire logic              error_irq
);
    // All checks run on pclk, off in reset.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_abort_equals_gate: assert property (protocol_abort == config_write_ok)
        else $error("gate differs");
    a_loop_tx_recessive: assert property (loopback_active |-> bus_transmit_pin)
        else $error("tx dominant in loop-back");
    a_no_sample_reset: assert property (protocol_abort |-> !sample_strobe)
        else $error("sample in soft reset");
    a_irq_quiet_reset: assert property (protocol_abort && $past(protocol_abort) |->
        !error_irq && !wake_irq) else $error("irq in soft reset");
    a_irq_fall_write: assert property ($fell(error_irq) || $fell(wake_irq) |->
        $past(psel && penable && pwrite || protocol_abort)) else $error("irq fell unprompted");
    a_rx_at_sample: assert property ($changed(rx_bit) |->
        $past(sample_strobe || protocol_abort)) else $error("rx bit off sample");
    a_config_locked: assert property ($changed(module_clock_select) |->
        $past(psel && penable && pwrite && (config_write_ok || paddr[ADDR_W-1:2] == 0)))
        else $error("clock select unlocked");
    a_ready_zero_wait: assert property (psel && penable |-> pready ##1 !penable || psel)
        else $error("no answer");
    a_slverr_range: assert property (psel && penable |-> pslverr == (paddr[ADDR_W-1:2] > 5))
        else $error("bad error response");
    // Main scenarios reached by the bench.
    c_loopback: cover property (loopback_active);
    c_error_irq: cover property ($rose(error_irq));
    c_wake_irq: cover property ($rose(wake_irq));
endmodule
bind cmtrf_core cmtrf_assertions #(.ADDR_W(ADDR_W)) cmtrf_assertions_i
(
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pready(pready), .pslverr(pslverr), .bus_transmit_pin(bus_transmit_pin),
    .rx_bit(rx_bit), .sample_strobe(sample_strobe), .protocol_abort(protocol_abort),
    .config_write_ok(config_write_ok), .loopback_active(loopback_active),
    .module_clock_select(module_clock_select), .wake_irq(wake_irq), .error_irq(error_irq)
);
`default_nettype wire

// ===== bench/cmtrf_bus_model.sv
// Wired-AND line with a remote node sending dominant pulses.
// Assumes dom_len is offered for one cycle.
`default_nettype none
module cmtrf_bus_model
(
    input  wire logic        pclk,
    input  wire logic        bus_transmit_pin,
    input  wire logic [15:0] dom_len,
    output logic             bus_receive_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] left_q = 16'h0000;
    // Remote node holds the line dominant for dom_len cycles.
    always_ff @(posedge pclk)
        left_q <= (dom_len != 16'h0000) ? dom_len : left_q - 16'((left_q != 16'h0000));
    // Any dominant driver wins the line.
    assign bus_receive_pin = bus_transmit_pin & (left_q == 16'h0000);
endmodule
`default_nettype wire

// ===== bench/tb.sv
// Register test of the block over APB.
// Assumes all other files are compiled first.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'h0;
    logic        presetn = 1'h0;
    logic        psel = 1'h0;
    logic        penable = 1'h0;
    logic        pwrite = 1'h0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, rx_pin, tx_pin, lb, wirq, eirq;
    logic        pll_tick = 1'h0;
    logic        xtal_tick = 1'h0;
    logic [7:0]  rxe = 8'h00;
    logic [8:0]  txe = 9'h000;
    logic [15:0] dom_len = 16'h0;
    int          failures = 0;
    int          n_compared = 0;
    cmtrf_core cmtrf_core_i
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(), .prdata(prdata),
        .pll_bus_clock(pll_tick), .crystal_clock(xtal_tick), .bus_receive_pin(rx_pin),
        .bus_transmit_pin(tx_pin), .tx_bit(1'h1), .tx_active(1'h0), .rx_err_count(rxe),
        .tx_err_count(txe), .rx_bit(), .sample_strobe(), .tx_point_strobe(),
        .protocol_abort(), .config_write_ok(), .loopback_active(lb),
        .module_clock_select(), .wake_irq(wirq), .error_irq(eirq)
    );
    cmtrf_bus_model cmtrf_bus_model_i
    (
        .pclk(pclk), .bus_transmit_pin(tx_pin), .dom_len(dom_len), .bus_receive_pin(rx_pin)
    );
    // 200 MHz clock; module ticks every second cycle.
    always #2.5 pclk = ~pclk;
    always @(posedge pclk)
    begin
        pll_tick <= ~pll_tick;
        xtal_tick <= pll_tick;
    end
    task automatic tally_and_finish(input int extra);
        failures += extra;
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer, held until pready is high.
    task automatic xfer(input logic w, input logic [5:0] i, input logic [7:0] d,
                        output logic [7:0] q);
        int n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= {i, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1 && n++ < 50)
            @(posedge pclk);
        q = prdata[7:0];
        psel <= 1'h0;
        penable <= 1'h0;
        if (n >= 50)
            tally_and_finish(1);
    endtask
    task automatic wr(input logic [5:0] i, input logic [7:0] d);
        logic [7:0] q;
        xfer(1'h1, i, d, q);
    endtask
    // Reads until the value shows or tries run out.
    task automatic rc(input logic [5:0] i, input logic [7:0] e, input int tries);
        logic [7:0] q;
        xfer(1'h0, i, 8'h00, q);
        while (q !== e && --tries > 0)
            xfer(1'h0, i, 8'h00, q);
        chk(q, e);
    endtask
    // Main sequence.
    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        rc(0, 8'h01, 1);
        rc(4, 8'h00, 1);
        wr(1, 8'h01);
        wr(2, 8'hc3);
        wr(3, 8'h27);
        rc(1, 8'h01, 1);
        rc(2, 8'hc3, 1);
        rc(3, 8'h27, 1);
        wr(0, 8'h00);
        wr(2, 8'h00);
        rc(2, 8'hc3, 1);
        rc(0, 8'h10, 4000);
        wr(5, 8'hfc);
        txe <= 9'd100;
        rc(4, 8'h20, 20);
        wr(4, 8'h20);
        rc(4, 8'h20, 1);
        chk({7'h0, eirq}, 8'h01);
        rxe <= 8'd200;
        txe <= 9'd300;
        rc(4, 8'h3c, 20);
        rxe <= 8'd0;
        txe <= 9'd0;
        wr(4, 8'hff);
        rc(4, 8'h00, 1);
        chk({7'h0, eirq}, 8'h00);
        wr(0, 8'h02);
        rc(0, 8'h16, 4000);
        dom_len <= 16'h0004;
        @(posedge pclk);
        dom_len <= 16'h0000;
        rc(4, 8'h80, 50);
        chk({7'h0, wirq}, 8'h01);
        wr(0, 8'h00);
        wr(4, 8'h80);
        wr(0, 8'h02);
        rc(0, 8'h16, 4000);
        wr(0, 8'h00);
        rc(4, 8'h00, 1);
        txe <= 9'd100;
        rc(4, 8'h20, 20);
        wr(0, 8'h01);
        rc(4, 8'h00, 1);
        rc(5, 8'h00, 1);
        rc(0, 8'h01, 1);
        wr(1, 8'h05);
        @(posedge pclk);
        chk({6'h0, lb, tx_pin}, 8'h03);
        rc(6, 8'h00, 1);
        tally_and_finish(0);
    end
endmodule
`default_nettype wire
